// *** rtl/als_pkg.sv ***
// Shared constants, enumerations and carrier structs of the ALU status flag block.
package als_pkg;
    // Register byte offsets on the APB bus.
    localparam logic [7:0] ADDR_X_BLOCK_STATUS_REG = 8'h00;
    localparam logic [7:0] ADDR_Y_BLOCK_STATUS_REG = 8'h04;
    localparam logic [7:0] ADDR_STATIC = 8'h08;
    // Status register field positions.
    localparam int ZERO_B = 0;
    localparam int NEG_B = 1;
    localparam int OVF_B = 2;
    localparam int CRY_B = 3;
    localparam int INV_B = 4;
    localparam int SUS_B = 5;
    localparam int SVS_B = 6;
    localparam int SOS_B = 7;
    localparam int SIS_B = 8;
    localparam int STAT_W = 9;
    // Reset values.
    localparam logic [8:0] STAT_RST = 9'h000;
    localparam logic [3:0] STATIC_RST = 4'h0;
    localparam logic [31:0] PR_RST = 32'h0000_0000;
    // Lane size codes: byte, short, long.
    localparam logic [1:0] LSZ_BYTE = 2'h0;
    localparam logic [1:0] LSZ_SHORT = 2'h1;
    localparam logic [1:0] LSZ_LONG = 2'h3;

    typedef enum logic [3:0] {
        OP_NOP, OP_ADD, OP_SUB, OP_AND, OP_ABS, OP_ABS_ADD, OP_ABS_SUB,
        OP_SUM, OP_SUM_PR, OP_FLOAT, OP_PR_LOAD, OP_PR_STORE
    } als_op_type;

    typedef enum logic [1:0] {FP_PLAIN, FP_ABS, FP_FRACTION_EXTRACT, FP_ABS_SUM} als_fp_type;

    typedef enum logic [3:0] {
        C_ALWAYS, C_EQ, C_LT, C_LE, C_NEQ, C_NLT, C_NLE, C_SF0, C_SF1
    } als_cond_type;

    // One ALU operation for the X (blk 0) or Y (blk 1) compute block.
    typedef struct packed {
        logic valid;
        logic blk;
        als_op_type op;
        logic [1:0] lsz;
        logic uns;
        logic sat;
        logic pr_sel;
        logic [63:0] a;
        logic [63:0] b;
        als_fp_type fp_kind;
        logic fp_pre_sign;
        logic fp_uflow;
        logic fp_ovf;
        logic fp_inv;
    } als_issue_type;

    // Condition header of one instruction line, plus static flag load.
    typedef struct packed {
        logic valid;
        als_cond_type cond;
        logic cblk;
        logic [2:0] do_mask;
        logic sf_load;
        logic sf_idx;
    } als_line_type;

    typedef struct packed {
        logic valid;
        logic blk;
        logic [63:0] data;
    } als_result_type;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } als_apb_req_type;

    typedef struct packed {
        logic [7:0] cout;
        logic [63:0] sum;
    } als_add_type;
endpackage : als_pkg

// *** rtl/als_status_top.sv ***
// ALU status flags, sticky flags, conditions, static flags and parallel result pair.
// Contract
// - Zero flag: fixed zero or float underflow.
// - Negative flag is result most significant bit.
// - Single abs and fraction extract: input sign.
// - Abs of sum/difference: pre-abs sign.
// - Overflow when result unrepresentable, signed default.
// - Overflow judged on final result only.
// - Carry from fixed add/sub; float clears.
// - Invalid from float ops; fixed clears.
// - Sticky float uflow/ovf/invalid, fixed overflow.
// - Sticky flags hold until software clears.
// - Flags visible to next cycle instruction.
// - Multi-result flags are OR over results.
// - Eight byte lanes add without cross carry.
// - Separate X and Y status registers.
// - Equal and less-or-equal conditions from flags.
// - Less-than and negated conditions provided.
// - One condition gates up to three slots.
// - Two static flags per block, testable.
// - Parallel result pair only via transfers.
// - Sideways sum accumulates into selected PR.
// - Saturation: ovf/carry pre, zero/neg post.
//
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module als_status_top (
    input wire logic ref_clk,
    input wire logic rst,
    input wire als_pkg::als_apb_req_type apb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire als_pkg::als_issue_type iss,
    input wire als_pkg::als_line_type line,
    output als_pkg::als_result_type result,
    output logic [2:0] slot_en,
    output logic slot_vld,
    output logic [8:0] x_status,
    output logic [8:0] y_status,
    output logic [3:0] static_bits
);
    // Status registers, index 0 is X and index 1 is Y.
    logic [8:0] stat_reg [2], stat_next [2];
    logic [3:0] static_reg;
    logic [31:0] pr_reg [2];
    logic [31:0] prdata_reg;
    logic [2:0] slot_en_reg;
    logic pready_reg, pslverr_reg, slot_vld_reg; // Bus handshake and slot strobe.
    als_pkg::als_result_type result_reg;
    // Datapath intermediates: lane sums, signs, per-lane flags and sideways sum.
    logic is_sub, is_abs, cur_s, cur_a, cur_o, zacc;
    logic l_zero, l_neg, l_ovf, l_cry, res_wr, apb_wr, cond_true;
    logic [63:0] bx, pre, flip, raw, fin, res_data;
    als_pkg::als_add_type add1, ab;
    logic [7:0] sgn, asg, ovf_b, ov_s, cry_b;
    logic [31:0] ss;
    logic [32:0] acc; // One spare bit keeps the accumulator carry.
    logic [8:0] f_upd, f_val, st_set;
    // Byte i closes a lane of the given size.
    function automatic logic is_top(input int i, input logic [1:0] lsz);
        return (i & ((1 << lsz) - 1)) == ((1 << lsz) - 1);
    endfunction : is_top
    // Byte i opens a lane of the given size.
    function automatic logic is_start(input int i, input logic [1:0] lsz);
        return (i & ((1 << lsz) - 1)) == 0;
    endfunction : is_start
    // Lane-split adder: the carry chain restarts at each lane start, so no carry
    // crosses a lane boundary; each lane takes its own carry-in.
    function automatic als_pkg::als_add_type lane_add(input logic [63:0] x,
            input logic [63:0] y, input logic [7:0] cin, input logic [1:0] lsz);
        als_pkg::als_add_type r;
        logic c;
        logic [8:0] s;
        r = '0;
        c = 1'b0;
        s = 9'h000;
        for (int i = 0; i < 8; i++) begin
            if (is_start(i, lsz)) begin
                c = cin[i];
            end
            s = {1'b0, x[8*i+:8]} + {1'b0, y[8*i+:8]} + {8'h00, c};
            r.sum[8*i+:8] = s[7:0];
            r.cout[i] = s[8];
            c = s[8];
        end
        return r;
    endfunction : lane_add
    // Lane arithmetic, saturation and per-lane flags ORed into one set.
    always_comb begin
        is_sub = (iss.op == als_pkg::OP_SUB) || (iss.op == als_pkg::OP_ABS_SUB);
        is_abs = (iss.op == als_pkg::OP_ABS) || (iss.op == als_pkg::OP_ABS_ADD) ||
                 (iss.op == als_pkg::OP_ABS_SUB);
        bx = is_sub ? ~iss.b : iss.b;
        add1 = lane_add(iss.a, bx, {8{is_sub}}, iss.lsz);
        // Single abs works on the operand, abs of sum on the sum.
        pre = (iss.op == als_pkg::OP_ABS) ? iss.a : add1.sum;
        sgn = 8'h00;
        asg = 8'h00;
        cur_s = 1'b0;
        cur_a = 1'b0;
        // Spread each lane's sign from its top byte down to all its bytes.
        for (int i = 7; i >= 0; i--) begin
            if (is_top(i, iss.lsz)) begin
                cur_s = pre[8*i+7];
                cur_a = iss.a[8*i+7];
            end
            sgn[i] = cur_s;
            asg[i] = cur_a;
        end
        flip = 64'h0;
        for (int i = 0; i < 8; i++) begin
            flip[8*i+:8] = pre[8*i+:8] ^ {8{sgn[i]}};
        end
        // Conditional negate: invert and add one in negative lanes only.
        ab = lane_add(flip, 64'h0, sgn, iss.lsz);
        raw = is_abs ? ab.sum : add1.sum;
        ovf_b = 8'h00;
        cry_b = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (is_top(i, iss.lsz)) begin
                // Judged on the final lane result, never on a partial sum.
                if (is_abs) begin
                    ovf_b[i] = ab.sum[8*i+7] || ((iss.op != als_pkg::OP_ABS) &&
                        (iss.a[8*i+7] == bx[8*i+7]) &&
                        (add1.sum[8*i+7] != iss.a[8*i+7]));
                end else if (iss.uns) begin
                    ovf_b[i] = add1.cout[i] ^ is_sub;
                end else begin
                    ovf_b[i] = (iss.a[8*i+7] == bx[8*i+7]) &&
                        (add1.sum[8*i+7] != iss.a[8*i+7]);
                end
                cry_b[i] = add1.cout[i] && (iss.op != als_pkg::OP_ABS);
            end
        end
        ov_s = 8'h00;
        cur_o = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            if (is_top(i, iss.lsz)) begin
                cur_o = ovf_b[i];
            end
            ov_s[i] = cur_o;
        end
        // Saturated bytes replace overflowed lanes; flags below see the result.
        fin = raw;
        for (int i = 0; i < 8; i++) begin
            if (iss.sat && ov_s[i]) begin
                if (iss.uns) begin
                    fin[8*i+:8] = {8{~is_sub}};
                end else if (is_top(i, iss.lsz)) begin
                    fin[8*i+:8] = {asg[i] && !is_abs, {7{!(asg[i] && !is_abs)}}};
                end else begin
                    fin[8*i+:8] = {8{asg[i] && !is_abs}};
                end
            end
        end
        l_zero = 1'b0;
        l_neg = 1'b0;
        zacc = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (is_start(i, iss.lsz)) begin
                zacc = 1'b1;
            end
            zacc = zacc && (fin[8*i+:8] == 8'h00);
            if (is_top(i, iss.lsz)) begin
                l_zero = l_zero || zacc;
                l_neg = l_neg || (is_abs ? sgn[i] : fin[8*i+7]);
            end
        end
        l_ovf = |ovf_b;
        l_cry = |cry_b;
        // Sideways sum over byte or short lanes of operand a.
        ss = 32'h0000_0000;
        for (int i = 0; i < 8; i++) begin
            if (iss.lsz == als_pkg::LSZ_BYTE) begin
                ss = ss + {{24{iss.a[8*i+7] && !iss.uns}}, iss.a[8*i+:8]};
            end else if (i < 4) begin
                ss = ss + {{16{iss.a[16*(i%4)+15] && !iss.uns}}, iss.a[16*(i%4)+:16]};
            end
        end
        acc = {1'b0, pr_reg[iss.pr_sel]} + {1'b0, ss};
    end
    // Which flags the operation writes and with what value.
    always_comb begin
        f_upd = 9'h000;
        f_val = 9'h000;
        st_set = 9'h000;
        res_wr = 1'b0;
        res_data = fin;
        unique case (iss.op)
            als_pkg::OP_ADD, als_pkg::OP_SUB, als_pkg::OP_ABS, als_pkg::OP_ABS_ADD,
            als_pkg::OP_ABS_SUB: begin
                f_upd = 9'h01f;
                f_val[als_pkg::ZERO_B] = l_zero;
                f_val[als_pkg::NEG_B] = l_neg;
                f_val[als_pkg::OVF_B] = l_ovf;
                f_val[als_pkg::CRY_B] = l_cry;
                st_set[als_pkg::SOS_B] = l_ovf;
                res_wr = 1'b1;
            end
            als_pkg::OP_AND: begin
                // Logic op: overflow is left as it was.
                f_upd = 9'h01b;
                res_data = iss.a & iss.b;
                f_val[als_pkg::ZERO_B] = (res_data == 64'h0);
                f_val[als_pkg::NEG_B] = res_data[63];
                res_wr = 1'b1;
            end
            als_pkg::OP_SUM: begin
                f_upd = 9'h01f;
                res_data = {32'h0000_0000, ss};
                f_val[als_pkg::ZERO_B] = (ss == 32'h0000_0000);
                f_val[als_pkg::NEG_B] = ss[31] && !iss.uns;
                res_wr = 1'b1;
            end
            als_pkg::OP_SUM_PR: begin
                f_upd = 9'h01f;
                f_val[als_pkg::ZERO_B] = (acc[31:0] == 32'h0000_0000);
                f_val[als_pkg::NEG_B] = acc[31];
                f_val[als_pkg::OVF_B] = (pr_reg[iss.pr_sel][31] == ss[31]) &&
                    (acc[31] != ss[31]);
                f_val[als_pkg::CRY_B] = acc[32];
                st_set[als_pkg::SOS_B] = f_val[als_pkg::OVF_B];
            end
            als_pkg::OP_FLOAT: begin
                f_upd = 9'h01f;
                res_data = iss.a;
                f_val[als_pkg::ZERO_B] = iss.fp_uflow;
                unique case (iss.fp_kind)
                    als_pkg::FP_PLAIN: f_val[als_pkg::NEG_B] = iss.a[31];
                    als_pkg::FP_ABS, als_pkg::FP_FRACTION_EXTRACT: f_val[als_pkg::NEG_B] = iss.b[31];
                    als_pkg::FP_ABS_SUM: f_val[als_pkg::NEG_B] = iss.fp_pre_sign;
                endcase
                f_val[als_pkg::OVF_B] = iss.fp_ovf;
                f_val[als_pkg::INV_B] = iss.fp_inv;
                st_set[als_pkg::SUS_B] = iss.fp_uflow;
                st_set[als_pkg::SVS_B] = iss.fp_ovf;
                st_set[als_pkg::SIS_B] = iss.fp_inv;
                res_wr = 1'b1;
            end
            als_pkg::OP_PR_STORE: begin
                // The pair always leaves whole.
                res_data = {pr_reg[1], pr_reg[0]};
                res_wr = 1'b1;
            end
            default: f_upd = 9'h000;
        endcase
    end
    // Next status: software write, then operation flags, then sticky sets.
    always_comb begin
        apb_wr = apb.psel && apb.penable && pready_reg && apb.pwrite;
        for (int k = 0; k < 2; k++) begin
            stat_next[k] = stat_reg[k];
            if (apb_wr && (apb.paddr == (k == 0 ? als_pkg::ADDR_X_BLOCK_STATUS_REG : als_pkg::ADDR_Y_BLOCK_STATUS_REG))) begin
                stat_next[k] = apb.pwdata[8:0];
            end
            // A colliding software write loses the dynamic flags to hardware.
            if (iss.valid && (iss.blk == k[0])) begin
                stat_next[k] = (stat_next[k] & ~f_upd) | (f_val & f_upd);
                stat_next[k] = stat_next[k] | st_set;
            end
        end
    end
    // Status registers update at the end of the operation cycle.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stat_reg[0] <= als_pkg::STAT_RST;
            stat_reg[1] <= als_pkg::STAT_RST;
        end else begin
            stat_reg[0] <= stat_next[0];
            stat_reg[1] <= stat_next[1];
        end
    end
    // Parallel result pair: reachable only from operand transfers and sums.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pr_reg[0] <= als_pkg::PR_RST;
            pr_reg[1] <= als_pkg::PR_RST;
        end else if (iss.valid && (iss.op == als_pkg::OP_PR_LOAD)) begin
            pr_reg[0] <= iss.a[31:0];
            pr_reg[1] <= iss.a[63:32];
        end else if (iss.valid && (iss.op == als_pkg::OP_SUM_PR)) begin
            pr_reg[iss.pr_sel] <= acc[31:0];
        end
    end
    // Result port, one-cycle valid per producing operation.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            result_reg <= '0;
        end else begin
            result_reg.valid <= iss.valid && res_wr;
            result_reg.blk <= iss.blk;
            result_reg.data <= res_data;
        end
    end
    // Condition evaluation on the flags as registered before this line.
    always_comb begin
        unique case (line.cond)
            als_pkg::C_ALWAYS: cond_true = 1'b1;
            als_pkg::C_EQ: cond_true = stat_reg[line.cblk][als_pkg::ZERO_B];
            als_pkg::C_LT: cond_true = stat_reg[line.cblk][als_pkg::NEG_B] &&
                !stat_reg[line.cblk][als_pkg::ZERO_B];
            als_pkg::C_LE: cond_true = stat_reg[line.cblk][als_pkg::NEG_B] ||
                stat_reg[line.cblk][als_pkg::ZERO_B];
            als_pkg::C_NEQ: cond_true = !stat_reg[line.cblk][als_pkg::ZERO_B];
            als_pkg::C_NLT: cond_true = !(stat_reg[line.cblk][als_pkg::NEG_B] &&
                !stat_reg[line.cblk][als_pkg::ZERO_B]);
            als_pkg::C_NLE: cond_true = !(stat_reg[line.cblk][als_pkg::NEG_B] ||
                stat_reg[line.cblk][als_pkg::ZERO_B]);
            als_pkg::C_SF0: cond_true = static_reg[{line.cblk, 1'b0}];
            als_pkg::C_SF1: cond_true = static_reg[{line.cblk, 1'b1}];
            default: cond_true = 1'b0;
        endcase
    end
    // Slot enables: marked slots follow the condition, others always run.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            slot_en_reg <= 3'h0;
            slot_vld_reg <= 1'b0;
        end else begin
            slot_vld_reg <= line.valid;
            slot_en_reg <= line.valid ? (~line.do_mask | {3{cond_true}}) : 3'h0;
        end
    end
    // Static flags: loaded from a condition or by software.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            static_reg <= als_pkg::STATIC_RST;
        end else if (line.valid && line.sf_load) begin
            static_reg[{line.cblk, line.sf_idx}] <= cond_true;
        end else if (apb_wr && (apb.paddr == als_pkg::ADDR_STATIC)) begin
            static_reg <= apb.pwdata[3:0];
        end
    end
    // APB slave: one wait state, error on unmapped addresses.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pready_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= apb.psel && apb.penable && !pready_reg;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            if (apb.psel && apb.penable && !pready_reg) begin
                unique case (apb.paddr)
                    als_pkg::ADDR_X_BLOCK_STATUS_REG: prdata_reg <= {23'h000000, stat_reg[0]};
                    als_pkg::ADDR_Y_BLOCK_STATUS_REG: prdata_reg <= {23'h000000, stat_reg[1]};
                    als_pkg::ADDR_STATIC: prdata_reg <= {28'h0000000, static_reg};
                    default: pslverr_reg <= 1'b1;
                endcase
            end
        end
    end
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign result = result_reg;
    assign slot_en = slot_en_reg;
    assign slot_vld = slot_vld_reg;
    assign x_status = stat_reg[0];
    assign y_status = stat_reg[1];
    assign static_bits = static_reg;
    // Checks on flag, condition and bus behaviour.
    a_sticky_hold: assert property (@(posedge ref_clk) disable iff (rst)
        $past(stat_reg[0][als_pkg::SOS_B]) && !$past(apb_wr) |-> stat_reg[0][als_pkg::SOS_B])
        else $error("Sticky overflow dropped without a clear.");
    a_float_clr_carry: assert property (@(posedge ref_clk) disable iff (rst)
        iss.valid && !iss.blk && iss.op == als_pkg::OP_FLOAT |=> !stat_reg[0][als_pkg::CRY_B])
        else $error("Float op left carry set.");
    a_fixed_clr_inv: assert property (@(posedge ref_clk) disable iff (rst)
        iss.valid && iss.blk && iss.op == als_pkg::OP_ADD |=> !stat_reg[1][als_pkg::INV_B])
        else $error("Fixed op left invalid set.");
    a_y_untouched: assert property (@(posedge ref_clk) disable iff (rst)
        iss.valid && !iss.blk && !apb_wr |=> $stable(stat_reg[1]))
        else $error("X op changed Y status.");
    a_byte_lane: assert property (@(posedge ref_clk) disable iff (rst)
        iss.valid && iss.op == als_pkg::OP_ADD && iss.lsz == als_pkg::LSZ_BYTE && !iss.sat
        |=> result.data[15:8] == 8'($past(iss.a[15:8]) + $past(iss.b[15:8])))
        else $error("Byte lanes leaked a carry.");
    a_abs_sign: assert property (@(posedge ref_clk) disable iff (rst)
        iss.valid && !iss.blk && iss.op == als_pkg::OP_ABS && iss.lsz == als_pkg::LSZ_LONG
        |=> stat_reg[0][als_pkg::NEG_B] == $past(iss.a[63]))
        else $error("Abs negative flag not input sign.");
    a_cond_eq: assert property (@(posedge ref_clk) disable iff (rst)
        line.valid && line.cond == als_pkg::C_EQ && line.do_mask == 3'h7
        |=> slot_en == {3{$past(stat_reg[line.cblk][als_pkg::ZERO_B])}})
        else $error("Equal-zero gating wrong.");
    a_uncond_slot: assert property (@(posedge ref_clk) disable iff (rst)
        line.valid && !line.do_mask[0] |=> slot_en[0] && slot_vld)
        else $error("Unmarked slot was suppressed.");
    a_pr_accum: assert property (@(posedge ref_clk) disable iff (rst)
        iss.valid && iss.op == als_pkg::OP_SUM_PR && !iss.pr_sel
        |=> pr_reg[0] == $past(pr_reg[0]) + $past(ss))
        else $error("Parallel result did not accumulate.");
    a_apb_wait: assert property (@(posedge ref_clk) disable iff (rst)
        apb.psel && apb.penable && !pready |=> pready ##1 !pready)
        else $error("APB ready not one cycle after wait.");
endmodule : als_status_top
`default_nettype wire

// *** verif/als_seq_model.sv ***
// Program sequencer stand-in that issues ALU operations and condition lines.
`timescale 1ns/100ps
`default_nettype none
module als_seq_model (
    input wire logic ref_clk,
    output als_pkg::als_issue_type iss,
    output als_pkg::als_line_type line
);
    // Both buses idle until the bench asks for traffic.
    initial begin
        iss = '0;
        line = '0;
    end
    // One op for one cycle; a 64-bit operand always moves whole, never as a half.
    task automatic issue(input als_pkg::als_issue_type t);
        @(posedge ref_clk);
        iss <= t;
        @(posedge ref_clk);
        iss <= '0;
    endtask : issue
    // One condition line for one cycle.
    task automatic cond(input als_pkg::als_line_type l);
        @(posedge ref_clk);
        line <= l;
        @(posedge ref_clk);
        line <= '0;
    endtask : cond
endmodule : als_seq_model
`default_nettype wire

// *** verif/als_status_top_tb.sv ***
// Self-checking bench of the ALU status flag block.
`timescale 1ns/100ps
`default_nettype none
module als_status_top_tb;
    typedef struct packed {
        logic [63:0] a;
        logic [63:0] b;
        logic [1:0] lsz;
        logic [63:0] dat;
        logic [8:0] st;
    } als_row_type;
    logic ref_clk;
    logic rst;
    als_pkg::als_apb_req_type apb;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    als_pkg::als_issue_type iss;
    als_pkg::als_line_type line;
    als_pkg::als_result_type result;
    logic [2:0] slot_en;
    logic slot_vld;
    logic [8:0] x_status;
    logic [8:0] y_status;
    logic [3:0] static_bits;
    int errors;
    int checked;
    logic [31:0] rd;
    logic er;
    als_pkg::als_issue_type t;
    als_row_type rows [4];
    als_status_top als_status_top_inst (.ref_clk(ref_clk), .rst(rst), .apb(apb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .iss(iss), .line(line),
        .result(result), .slot_en(slot_en), .slot_vld(slot_vld), .x_status(x_status),
        .y_status(y_status), .static_bits(static_bits));
    als_seq_model als_seq_model_inst (.ref_clk(ref_clk), .iss(iss), .line(line));
    // Free-running 10 MHz clock.
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    task automatic close_out();
        $display("compares %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        checked++;
        if (g !== e) begin
            errors++;
            $display("wrong value at %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    // One APB transfer; waits for pready a bounded number of edges.
    task automatic apb_rw(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        apb <= '{1'b1, 1'b0, w, ad, d};
        @(posedge ref_clk);
        apb.penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        apb <= '0;
        if (pready !== 1'b1) begin
            errors++;
            close_out();
        end
    endtask : apb_rw
    // A hang is cut short here.
    initial begin
        repeat (3000) @(posedge ref_clk);
        errors++;
        close_out();
    end
    initial begin
        rst = 1'b1;
        apb = '0;
        // Sticky fixed overflow (bit 7) stays once row 2 sets it.
        rows[0] = '{64'h0, 64'h0, als_pkg::LSZ_LONG, 64'h0, 9'h001};
        rows[1] = '{64'h8000_0000_0000_0000, 64'h0, als_pkg::LSZ_LONG,
            64'h8000_0000_0000_0000, 9'h002};
        rows[2] = '{64'h7fff_ffff_ffff_ffff, 64'h1, als_pkg::LSZ_LONG,
            64'h8000_0000_0000_0000, 9'h086};
        // Byte lane 0 wraps to zero with a carry that must not reach lane 1.
        rows[3] = '{64'h1ff, 64'h1, als_pkg::LSZ_BYTE, 64'h100, 9'h089};
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        #1;
        chk(64'(x_status), 64'h0);
        $display("reset test done");
        foreach (rows[i]) begin
            t = '0;
            t.valid = 1'b1;
            t.op = als_pkg::OP_ADD;
            t.a = rows[i].a;
            t.b = rows[i].b;
            t.lsz = rows[i].lsz;
            als_seq_model_inst.issue(t);
            #1;
            chk(64'(result.valid), 64'h1);
            chk(result.data, rows[i].dat);
            chk(64'(x_status), 64'(rows[i].st));
        end
        $display("row test done");
        t = '0;
        t.valid = 1'b1;
        t.op = als_pkg::OP_FLOAT;
        t.fp_inv = 1'b1;
        als_seq_model_inst.issue(t);
        #1;
        chk(64'(x_status), 64'h190);
        chk(64'(y_status), 64'h0);
        als_seq_model_inst.cond('{1'b1, als_pkg::C_EQ, 1'b0, 3'h3, 1'b0, 1'b0});
        #1;
        chk(64'(slot_en), 64'h4);
        als_seq_model_inst.cond('{1'b1, als_pkg::C_NEQ, 1'b0, 3'h7, 1'b1, 1'b1});
        #1;
        chk(64'(slot_en), 64'h7);
        chk(64'(static_bits), 64'h2);
        als_seq_model_inst.cond('{1'b1, als_pkg::C_EQ, 1'b0, 3'h7, 1'b0, 1'b0});
        #1;
        chk(64'(slot_en), 64'h0);
        als_seq_model_inst.cond('{1'b1, als_pkg::C_LT, 1'b1, 3'h6, 1'b0, 1'b0});
        #1;
        chk(64'(slot_en), 64'h1);
        $display("condition test done");
        apb_rw(1'b0, als_pkg::ADDR_X_BLOCK_STATUS_REG, 32'h0);
        chk(64'(rd), 64'h190);
        // No op is in flight while software writes status.
        apb_rw(1'b1, als_pkg::ADDR_X_BLOCK_STATUS_REG, 32'h0);
        apb_rw(1'b0, als_pkg::ADDR_X_BLOCK_STATUS_REG, 32'h0);
        chk(64'(rd), 64'h0);
        apb_rw(1'b0, 8'h0c, 32'h0);
        chk(64'(er), 64'h1);
        $display("register test done");
        // Single abs reports the input sign; Y float then Y fixed op.
        t = '0;
        t.valid = 1'b1;
        t.op = als_pkg::OP_ABS;
        t.lsz = als_pkg::LSZ_LONG;
        t.a = 64'hffff_ffff_ffff_fffe;
        als_seq_model_inst.issue(t);
        #1;
        chk(result.data, 64'h2);
        chk(64'(x_status), 64'h002);
        t.blk = 1'b1;
        t.op = als_pkg::OP_FLOAT;
        t.fp_inv = 1'b1;
        als_seq_model_inst.issue(t);
        t.op = als_pkg::OP_ADD;
        t.a = 64'h0;
        als_seq_model_inst.issue(t);
        #1;
        chk(64'(y_status), 64'h101);
        // Pair load, byte sideways sum into the low half, then pair store.
        t.op = als_pkg::OP_PR_LOAD;
        t.a = 64'h0000_0005_0000_0003;
        als_seq_model_inst.issue(t);
        t.op = als_pkg::OP_SUM_PR;
        t.lsz = als_pkg::LSZ_BYTE;
        t.a = 64'h0001_0002_0003_0004;
        als_seq_model_inst.issue(t);
        t.op = als_pkg::OP_PR_STORE;
        als_seq_model_inst.issue(t);
        #1;
        chk(result.data, 64'h0000_0005_0000_000d);
        $display("alu test done");
        close_out();
    end
endmodule : als_status_top_tb
`default_nettype wire
